// >>> design/rsgen_consts.svh
// constants of the reset source generation block: offsets, fields, counts
// assumes inclusion by bare name from the top module, the checker and the bench
// Summary of operation
// RULE1: watchdog expiry from the 1 kHz-clocked timer becomes a watchdog reset source.
// RULE2: cpu software reset request becomes the software reset source.
// RULE3: failed option-byte check at startup raises the option-failure reset source.
// RULE4: each failure restarts and rechecks; third consecutive failure parks in emulated deep sleep.
// RULE5: readout protection forced active while parked after repeated option failures.
// RULE6: debugger reset request bit becomes a debug reset source.
// RULE7: jtag reset resets only the test access port, independent of everything else.
// RULE8: jtag reset ignored in serial-wire mode or with debug port disabled.
// RULE9: deep-sleep reset held from entry until core power detector reports good.
// RULE10: emulated deep sleep keeps core and memory powered, sequencing otherwise proceeds.
// RULE11: only latest restart cause recorded, one flag, option failure may join original.
// RULE12: cpu lockup sets its flag but applies no reset.
// RULE13: full reset clears cpu and debug; system reset clears only cpu.
// RULE14: separate always-on and core peripheral resets.
// RULE15: always-on power-on, or core power-on outside sleep, asserts all five resets.
// RULE16: core power-on in sleep and normal sleep assert all but always-on peripheral.
// RULE17: pin asserts all but debug port; watchdog, software assert system and peripherals.
// RULE18: option failure full, system, core periph; emulated sleep system, core; debug system.
// RULE19: cause bits 0..7 power-hv, power-lv, pin, wdt, sw, wake, optfail, lockup.
// RULE20: always-on power flag reads one; reset value only bit 0 set.
// RULE21: writes to cause register ignored; only reset logic updates it.
`ifndef RSGEN_CONSTS_SVH
`define RSGEN_CONSTS_SVH
`define RSGEN_ADDR_W         32
`define RSGEN_CAUSE_ADDR     32'h4000002C
`define RSGEN_CAUSE_RESET    8'h01
`define RSGEN_BIT_ALWAYS_ON_POWER_FLAG      0
`define RSGEN_BIT_CORE_POWER_FLAG      1
`define RSGEN_BIT_PIN        2
`define RSGEN_BIT_WDT        3
`define RSGEN_BIT_SW         4
`define RSGEN_BIT_WAKE       5
`define RSGEN_BIT_OPTFAIL    6
`define RSGEN_BIT_LOCKUP     7
`define RSGEN_OPT_MAX_TRIES  2'h3
`define RSGEN_HOLD_CYCLES    4'h4
`endif

// >>> design/rsgen_pkg.sv
// types of the reset source generation block
// uses nothing from the constants header
package rsgen_pkg;
    // one bit per reset output
    typedef struct packed {
        logic fullCpu;
        logic cpuOnly;
        logic dap;
        logic aonPeriph;
        logic corePeriph;
    } rsgen_outs_t;
    typedef enum logic [1:0] {RSGEN_RUN, RSGEN_HOLD, RSGEN_SLEEP, RSGEN_PARK}
        rsgen_state_t;
endpackage

// >>> design/rsgen_top.sv
// reset source generation: collects sources, drives five reset outputs,
// records last restart cause; one clock, synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
`include "rsgen_consts.svh"
module rsgen_top (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        srst,
    // reset sources
    input  wire logic        alwaysOnPowerDetect,
    input  wire logic        corePowerDetect,
    input  wire logic        externalResetPin,
    input  wire logic        wdtExpire,
    input  wire logic        cpuSwResetRequest,
    input  wire logic        optionCheckFailSource,
    input  wire logic        debuggerResetRequest,
    input  wire logic        deepSleepActive,
    input  wire logic        emulatedSleepReq,
    input  wire logic        cpuLockup,
    // jtag
    input  wire logic        jtagResetIn,
    input  wire logic        serialWireMode,
    input  wire logic        combinedDebugEnable,
    // register port
    input  wire logic [31:0] regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    // outputs
    output logic [31:0]      regRdata,
    output logic             fullCpuDebugReset,
    output logic             cpuOnlyReset,
    output logic             debugAccessPortReset,
    output logic             alwaysOnPeriphReset,
    output logic             corePeriphReset,
    output logic             tapReset,
    output logic             readoutProtectForce,
    output logic             emulatedSleep,
    output logic             cpuLockupFlag
);
    import rsgen_pkg::*;

    // map of one source to its reset outputs
    function automatic rsgen_outs_t mapOf(input logic fc, input logic co,
        input logic dp, input logic ao, input logic cp);
        rsgen_outs_t m;
        m.fullCpu    = fc;
        m.cpuOnly    = co;
        m.dap        = dp;
        m.aonPeriph  = ao;
        m.corePeriph = cp;
        return m;
    endfunction

    rsgen_state_t state_r;
    rsgen_state_t state_nxt;
    logic [7:0]   cause_r;
    logic [7:0]   cause_nxt;
    logic [1:0]   optFails_r;
    logic [1:0]   optFails_nxt;
    logic [3:0]   hold_r;
    logic [3:0]   hold_nxt;
    rsgen_outs_t  outs_r;
    rsgen_outs_t  outs_nxt;
    logic         tap_r;
    logic         rdp_r;
    logic         lock_r;
    logic [31:0]  rdata_r;

    // per-source maps
    wire porHv     = ~alwaysOnPowerDetect;
    wire porLv     = ~corePowerDetect;
    wire inSleep   = deepSleepActive | (state_r == RSGEN_SLEEP);
    wire parked    = (state_r == RSGEN_PARK);
    wire optFail   = optionCheckFailSource & ~parked;          // [RULE3]
    wire lastFail  = optFail
                     & (optFails_r == `RSGEN_OPT_MAX_TRIES - 2'h1);
    wire emuSleep  = emulatedSleepReq | parked;                // [RULE10]
    wire dbgEn     = combinedDebugEnable & ~serialWireMode;

    rsgen_outs_t mPorHv;
    rsgen_outs_t mPorLv;
    rsgen_outs_t mPin;
    rsgen_outs_t mWdtSw;
    rsgen_outs_t mOpt;
    rsgen_outs_t mSleep;
    rsgen_outs_t mEmu;
    rsgen_outs_t mDbg;
    rsgen_outs_t asserted;
    // [RULE15] [RULE16]
    assign mPorHv = porHv ? mapOf(1'b1, 1'b1, 1'b1, 1'b1, 1'b1) : '0;
    assign mPorLv = porLv ? mapOf(1'b1, 1'b1, 1'b1, ~inSleep, 1'b1) : '0;
    // [RULE17]
    assign mPin   = externalResetPin
                    ? mapOf(1'b1, 1'b1, 1'b0, 1'b1, 1'b1) : '0;
    // [RULE1] [RULE2]
    assign mWdtSw = (wdtExpire | cpuSwResetRequest)
                    ? mapOf(1'b0, 1'b1, 1'b0, 1'b1, 1'b1) : '0;
    // [RULE18]
    assign mOpt   = optFail ? mapOf(1'b1, 1'b1, 1'b0, 1'b0, 1'b1) : '0;
    // [RULE9]
    assign mSleep = inSleep ? mapOf(1'b1, 1'b1, 1'b1, 1'b0, 1'b1) : '0;
    assign mEmu   = emuSleep ? mapOf(1'b0, 1'b1, 1'b0, 1'b0, 1'b1) : '0;
    // [RULE6]
    assign mDbg   = debuggerResetRequest
                    ? mapOf(1'b0, 1'b1, 1'b0, 1'b0, 1'b0) : '0;
    assign asserted = mPorHv | mPorLv | mPin | mWdtSw | mOpt | mSleep
                      | mEmu | mDbg;

    // any restart source present this cycle
    wire anySrc = porHv | porLv | externalResetPin | wdtExpire
                  | cpuSwResetRequest | optFail | debuggerResetRequest;

    // sleep and park sequencing
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            RSGEN_RUN: begin
                if (lastFail) begin
                    state_nxt = RSGEN_PARK;                    // [RULE4]
                end else if (deepSleepActive) begin
                    state_nxt = RSGEN_SLEEP;
                end else if (anySrc) begin
                    state_nxt = RSGEN_HOLD;
                end
            end
            RSGEN_HOLD: begin
                if (lastFail) begin
                    state_nxt = RSGEN_PARK;
                end else if (!anySrc && hold_r == 4'h0) begin
                    state_nxt = RSGEN_RUN;
                end
            end
            // held until wake and core power good
            RSGEN_SLEEP: begin
                if (!deepSleepActive && corePowerDetect) begin
                    state_nxt = RSGEN_RUN;                     // [RULE9]
                end
            end
            // left only by power-on or pin
            RSGEN_PARK: begin
                if (porHv || porLv || externalResetPin) begin
                    state_nxt = RSGEN_HOLD;
                end
            end
            default: state_nxt = RSGEN_RUN;
        endcase
    end

    assign hold_nxt = anySrc ? `RSGEN_HOLD_CYCLES
                    : (hold_r != 4'h0 ? hold_r - 4'h1 : 4'h0);
    assign outs_nxt = asserted
                      | ((state_r == RSGEN_HOLD && hold_r != 4'h0)
                         ? outs_r : '0);

    // consecutive option failures; cleared by a pin reset or power-on
    assign optFails_nxt = (porHv || porLv || externalResetPin) ? 2'h0
                        : lastFail ? optFails_r
                        : optFail  ? optFails_r + 2'h1
                        : optFails_r;

    // cause recording: newest cause wins, option failure kept alongside
    // always-on power-on restarts everything: cause falls back to bit 0 only
    wire newCause = porHv | porLv | externalResetPin | wdtExpire
                    | cpuSwResetRequest
                    | (state_r == RSGEN_SLEEP && state_nxt == RSGEN_RUN);
    logic [7:0] causeBase;
    always_comb begin
        causeBase = 8'h00;
        if (porHv) begin
            causeBase = 8'h00;
        end else if (porLv && !inSleep) begin
            causeBase[`RSGEN_BIT_CORE_POWER_FLAG] = 1'b1;
        end else if (externalResetPin) begin
            causeBase[`RSGEN_BIT_PIN] = 1'b1;
        end else if (wdtExpire) begin
            causeBase[`RSGEN_BIT_WDT] = 1'b1;
        end else if (cpuSwResetRequest) begin
            causeBase[`RSGEN_BIT_SW] = 1'b1;
        end else begin
            causeBase[`RSGEN_BIT_WAKE] = 1'b1;
        end
    end
    // [RULE11] [RULE19] [RULE20] [RULE21]
    always_comb begin
        cause_nxt = cause_r;
        if (newCause) begin
            cause_nxt = causeBase | `RSGEN_CAUSE_RESET;
        end
        if (optFail) begin
            cause_nxt[`RSGEN_BIT_OPTFAIL] = 1'b1;
        end
        if (cpuLockup) begin
            cause_nxt[`RSGEN_BIT_LOCKUP] = 1'b1;               // [RULE12]
        end
    end

    wire hitCause = (regAddr == `RSGEN_CAUSE_ADDR);
    wire [31:0] rdataNxt = (regRead && hitCause) ? {24'h000000, cause_r}
                                                 : 32'h00000000;

    always_ff @(posedge clock) begin
        if (srst) begin
            state_r    <= RSGEN_RUN;
            cause_r    <= `RSGEN_CAUSE_RESET;
            optFails_r <= 2'h0;
            hold_r     <= 4'h0;
            outs_r     <= '1;
            tap_r      <= 1'b0;
            rdp_r      <= 1'b0;
            lock_r     <= 1'b0;
            rdata_r    <= 32'h00000000;
        end else begin
            state_r    <= state_nxt;
            cause_r    <= cause_nxt;
            optFails_r <= optFails_nxt;
            hold_r     <= hold_nxt;
            outs_r     <= outs_nxt;
            tap_r      <= jtagResetIn & dbgEn;                 // [RULE7] [RULE8]
            rdp_r      <= (state_nxt == RSGEN_PARK);            // [RULE5]
            lock_r     <= cpuLockup;                           // [RULE12]
            rdata_r    <= rdataNxt;
        end
    end

    // [RULE13] [RULE14]
    assign fullCpuDebugReset    = outs_r.fullCpu;
    assign cpuOnlyReset         = outs_r.cpuOnly;
    assign debugAccessPortReset = outs_r.dap;
    assign alwaysOnPeriphReset  = outs_r.aonPeriph;
    assign corePeriphReset      = outs_r.corePeriph;
    assign tapReset             = tap_r;
    assign readoutProtectForce  = rdp_r;
    assign emulatedSleep        = rdp_r;
    assign cpuLockupFlag        = lock_r;
    assign regRdata             = rdata_r;
endmodule
`default_nettype wire

// >>> verification/rsgen_cpu_model.sv
// cpu core model: raises the software reset request on command
// assumes the bench pulses go for one cycle after a rising edge
`timescale 1ns/10ps
`default_nettype none
module rsgen_cpu_model (
    // clock and reset
    input  wire logic clock,
    input  wire logic srst,
    // command and answer
    input  wire logic go,
    input  wire logic cpuOnlyReset,
    output logic      swReq
);
    // request drops once the core sees its own reset
    always_ff @(posedge clock) begin
        if (srst)
            swReq <= 1'b0;
        else if (go)
            swReq <= 1'b1;
        else if (cpuOnlyReset)
            swReq <= 1'b0;
    end
endmodule
`default_nettype wire

// >>> verification/rsgen_top_assertions.sv
// checker of the reset source generation ports
// assumes the constants header on the include path
`timescale 1ns/10ps
`default_nettype none
`include "rsgen_consts.svh"
module rsgen_top_chk (
    input wire logic clock, srst, alwaysOnPowerDetect, externalResetPin,
    input wire logic wdtExpire, optionCheckFailSource, debuggerResetRequest,
    input wire logic cpuLockup, serialWireMode, combinedDebugEnable, regRead,
    input wire logic [31:0] regAddr, regRdata,
    input wire logic fullCpuDebugReset, cpuOnlyReset, debugAccessPortReset,
    input wire logic alwaysOnPeriphReset, corePeriphReset, tapReset,
    input wire logic readoutProtectForce, emulatedSleep, cpuLockupFlag
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    wire causeHit = regRead && regAddr == `RSGEN_CAUSE_ADDR;
    a_aon_all: assert property (!alwaysOnPowerDetect |=> fullCpuDebugReset
        && cpuOnlyReset && debugAccessPortReset && alwaysOnPeriphReset
        && corePeriphReset) else $error("aon power-on resets missing");
    a_pin_map: assert property (externalResetPin |=> fullCpuDebugReset
        && cpuOnlyReset && alwaysOnPeriphReset && corePeriphReset)
        else $error("pin resets missing");
    a_wdt_map: assert property (wdtExpire |=> cpuOnlyReset
        && alwaysOnPeriphReset && corePeriphReset) else $error("wdt resets");
    a_opt_map: assert property (optionCheckFailSource && !readoutProtectForce |=>
        fullCpuDebugReset && cpuOnlyReset && corePeriphReset)
        else $error("option failure resets missing");
    a_dbg_sys: assert property (debuggerResetRequest |=> cpuOnlyReset)
        else $error("debug reset missing");
    a_tap_off: assert property (serialWireMode || !combinedDebugEnable
        |=> !tapReset) else $error("jtag reset not ignored");
    a_lock_flag: assert property ($rose(cpuLockup) |=> cpuLockupFlag)
        else $error("lockup flag missing");
    a_park_hold: assert property (readoutProtectForce |-> emulatedSleep
        && cpuOnlyReset && corePeriphReset) else $error("park state");
    a_read_hv: assert property (causeHit |=> regRdata[0]
        && regRdata[31:8] == 24'h000000) else $error("cause read bad");
    a_read_miss: assert property (regRead && !causeHit |=>
        regRdata == 32'h00000000) else $error("unmapped read not zero");
    c_park: cover property ($rose(readoutProtectForce));
    c_tap: cover property (tapReset);
    c_read: cover property (causeHit);
endmodule
bind rsgen_top rsgen_top_chk rsgen_top_chk_inst (.clock(clock), .srst(srst),
    .alwaysOnPowerDetect(alwaysOnPowerDetect), .externalResetPin(externalResetPin),
    .wdtExpire(wdtExpire), .optionCheckFailSource(optionCheckFailSource),
    .debuggerResetRequest(debuggerResetRequest), .cpuLockup(cpuLockup),
    .serialWireMode(serialWireMode), .combinedDebugEnable(combinedDebugEnable),
    .regRead(regRead), .regAddr(regAddr), .regRdata(regRdata),
    .fullCpuDebugReset(fullCpuDebugReset), .cpuOnlyReset(cpuOnlyReset),
    .debugAccessPortReset(debugAccessPortReset), .tapReset(tapReset),
    .alwaysOnPeriphReset(alwaysOnPeriphReset), .corePeriphReset(corePeriphReset),
    .readoutProtectForce(readoutProtectForce), .emulatedSleep(emulatedSleep),
    .cpuLockupFlag(cpuLockupFlag));
`default_nettype wire

// >>> verification/rsgen_top_tb.sv
// bench of the reset source generation block
// assumes the design, cpu model and checker compiled before it
`timescale 1ns/10ps
`default_nettype none
`include "rsgen_consts.svh"
module rsgen_top_tb;
    logic clock, srst, swGo, jtag, swMode, dbgEn, regWrite, regRead, swReq;
    logic tapReset, roForce, emuSleep, lockFlag;
    logic [8:0] src;
    logic [4:0] outs;
    logic [31:0] regAddr, regWdata, regRdata;
    logic [7:0] cause;
    int errTotal, cmpCount, optCnt, k, seed;
    // full, system, dap, always-on, core per source
    localparam logic [4:0] MAP [9] = '{5'h1F, 5'h1F, 5'h1B, 5'h0B, 5'h0B,
        5'h19, 5'h08, 5'h09, 5'h00};
    rsgen_cpu_model rsgen_cpu_model_inst (.clock(clock), .srst(srst),
        .go(swGo), .cpuOnlyReset(outs[3]), .swReq(swReq));
    rsgen_top rsgen_top_inst (.clock(clock), .srst(srst),
        .alwaysOnPowerDetect(~src[0]), .corePowerDetect(~src[1]),
        .externalResetPin(src[2]), .wdtExpire(src[3]),
        .cpuSwResetRequest(swReq), .optionCheckFailSource(src[5]),
        .debuggerResetRequest(src[6]), .deepSleepActive(1'b0),
        .emulatedSleepReq(src[7]), .cpuLockup(src[8]), .jtagResetIn(jtag),
        .serialWireMode(swMode), .combinedDebugEnable(dbgEn),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .fullCpuDebugReset(outs[4]),
        .cpuOnlyReset(outs[3]), .debugAccessPortReset(outs[2]),
        .alwaysOnPeriphReset(outs[1]), .corePeriphReset(outs[0]),
        .tapReset(tapReset), .readoutProtectForce(roForce),
        .emulatedSleep(emuSleep), .cpuLockupFlag(lockFlag));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            errTotal++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        @(posedge clock);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRead <= 1'b0;
        #1 chk(regRdata, e);
    endtask
    // pulse one source, check the map, the hold end and the cause
    task automatic fire(input int s, input bit chkCause);
        @(posedge clock);
        if (s == 4) swGo <= 1'b1;
        else src[s] <= 1'b1;
        @(posedge clock);
        swGo <= 1'b0;
        src <= '0;
        if (s == 4) @(posedge clock);
        #1 chk(outs, (s == 5 && optCnt >= 3 ? 5'h00 : MAP[s]) | (optCnt >= 3 ? 5'h09 : 5'h00));
        if (s == 8) chk(lockFlag, 1);
        repeat (10) @(posedge clock);
        case (s)
            0: cause = 8'h01;
            1: cause = 8'h03;
            2: cause = 8'h05;
            3: cause = 8'h09;
            4: cause = 8'h11;
            5: cause = cause | 8'h40;
            8: cause = cause | 8'h80;
            default: ;
        endcase
        if (s == 5) optCnt = (optCnt >= 3) ? optCnt : optCnt + 1;
        else if (s < 3) optCnt = 0;
        #1 chk(outs, optCnt >= 3 ? 5'h09 : 5'h00);
        chk(roForce, optCnt >= 3);
        chk(emuSleep, optCnt >= 3);
        if (chkCause) rd(`RSGEN_CAUSE_ADDR, cause);
        $display("test source %0d done", s);
    endtask
    task automatic completeRun;
        $display("comparisons %0d mismatches %0d", cmpCount, errTotal);
        if (errTotal == 0 && cmpCount > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #900000 errTotal++;
        completeRun();
    end
    initial begin
        {srst, swGo, jtag, swMode, dbgEn, regWrite, regRead} = 7'h40;
        {src, regAddr, regWdata, errTotal, cmpCount, optCnt} = '0;
        cause = 8'h01;
        seed = 32;
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        rd(`RSGEN_CAUSE_ADDR, 32'h00000001);
        @(posedge clock);
        regWrite <= 1'b1;
        regAddr <= `RSGEN_CAUSE_ADDR;
        regWdata <= $random(seed);
        @(posedge clock);
        regWrite <= 1'b0;
        rd(`RSGEN_CAUSE_ADDR, 32'h00000001);
        rd(`RSGEN_CAUSE_ADDR + 32'h4, 32'h00000000);
        repeat (10) @(posedge clock);
        for (k = 0; k < 4; k++) begin
            @(posedge clock);
            jtag <= 1'b1;
            {dbgEn, swMode} <= k[1:0];
            @(posedge clock);
            jtag <= 1'b0;
            #1 chk(tapReset, k == 2);
            chk(outs, 5'h00);
        end
        $display("test jtag done");
        for (k = 0; k < 9; k++) fire(k < 3 ? 5 : k - 1, 1);
        repeat (40) begin
            k = $unsigned($random(seed)) % 8;
            fire(k == 7 ? 8 : k, 1);
        end
        fire(7, 0);
        completeRun();
    end
endmodule
`default_nettype wire
